//--- load_ctrl_assertions.sv
// Purpose: Port checks for the load request and safety loop controller
// Assumes: Contacts high active, loop pin high when closed
// Notes: Age counters bound how long a voted contact outlives its pin
`timescale 1ns/1ps

module load_ctrl_assertions
#(
  parameter int TICK_CYCLES = 4
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic heatReqPin,
  input wire logic loadClosePin,
  input wire logic loadOpenPin,
  input wire logic safetyLoopPin,
  input wire logic actuatorLowDrive,
  input wire logic actuatorHighDrive,
  input wire logic fuelValve,
  input wire logic fanMotor,
  input wire logic ignition,
  input wire logic loopSupply,
  input wire logic alarm,
  input wire logic operating_phase
);
  // Vote needs about three ticks to clear, plus sync and output stages
  localparam int AGE_LIM = 6 * TICK_CYCLES + 10;
  int heatAge_reg;
  int openAge_reg;
  int closeAge_reg;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      heatAge_reg <= AGE_LIM;
      openAge_reg <= AGE_LIM;
      closeAge_reg <= AGE_LIM;
    end
    else
    begin
      heatAge_reg <= heatReqPin ? 0 : (heatAge_reg < AGE_LIM ? heatAge_reg + 1 : AGE_LIM);
      openAge_reg <= loadOpenPin ? 0 : (openAge_reg < AGE_LIM ? openAge_reg + 1 : AGE_LIM);
      closeAge_reg <= loadClosePin ? 0 : (closeAge_reg < AGE_LIM ? closeAge_reg + 1 : AGE_LIM);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_loopCut;
    !safetyLoopPin [*5] |-> !(fuelValve || fanMotor || ignition);
  endproperty
  a_loopCut: assert property (p_loopCut) else $error("Outputs live with loop open");
  property p_alarmSupply;
    alarm |-> !loopSupply;
  endproperty
  a_alarmSupply: assert property (p_alarmSupply) else $error("Loop supply on in lockout");
  property p_alarmCut;
    alarm |-> !(fuelValve || fanMotor || ignition);
  endproperty
  a_alarmCut: assert property (p_alarmCut) else $error("Outputs live in lockout");
  property p_noBoth;
    operating_phase |-> !(actuatorLowDrive && actuatorHighDrive);
  endproperty
  a_noBoth: assert property (p_noBoth) else $error("Both actuator drives on");
  property p_openAge;
    operating_phase && actuatorHighDrive |-> openAge_reg < AGE_LIM;
  endproperty
  a_openAge: assert property (p_openAge) else $error("High drive without open contact");
  property p_closeAge;
    operating_phase && actuatorLowDrive |-> closeAge_reg < AGE_LIM;
  endproperty
  a_closeAge: assert property (p_closeAge) else $error("Low drive without close contact");
  property p_fanStart;
    $rose(fanMotor) |-> heatAge_reg < AGE_LIM;
  endproperty
  a_fanStart: assert property (p_fanStart) else $error("Start without heat request");
  property p_supplyHeat;
    loopSupply |-> heatAge_reg < AGE_LIM;
  endproperty
  a_supplyHeat: assert property (p_supplyHeat) else $error("Loop supply without heat request");
endmodule // load_ctrl_assertions

bind load_request_safety_loop_ctrl load_ctrl_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .heatReqPin(heatReqPin), .loadClosePin(loadClosePin),
  .loadOpenPin(loadOpenPin), .safetyLoopPin(safetyLoopPin), .actuatorLowDrive(actuatorLowDrive),
  .actuatorHighDrive(actuatorHighDrive), .fuelValve(fuelValve), .fanMotor(fanMotor), .ignition(ignition),
  .loopSupply(loopSupply), .alarm(alarm), .operating_phase(operating_phase));

//--- load_ctrl_params.svh
// Purpose: Constants for the load request and safety loop controller
// Assumes: 50 MHz system clock, contact sampling period of 150 ms
// Notes: Phase times are held in units of one sampling period
`ifndef LOAD_CTRL_PARAMS_SVH
`define LOAD_CTRL_PARAMS_SVH

`define CLK_PERIOD_NS 20
`define SAMPLE_PERIOD_MS 150
`define SAMPLE_CYCLES ((`SAMPLE_PERIOD_MS * 1_000_000) / `CLK_PERIOD_NS)
`define FORCED_STOP_MS 86_400_000
`define FORCED_STOP_TICKS (`FORCED_STOP_MS / `SAMPLE_PERIOD_MS)
`define TICK_W 23
`define RUN_W 20

`define REG_CONFIG 8'h00
`define REG_SHUT_TIME 8'h04
`define REG_PURGE_TIME 8'h08
`define REG_POST_TIME 8'h0C
`define REG_PROVE_TIME 8'h10
`define REG_STATUS 8'h14
`define REG_COMMAND 8'h18

`define CFG_W 9
`define CFG_ACT_ON 0
`define CFG_MODE_LSB 1
`define CFG_MODE_MSB 2
`define CFG_SEL_LSB 3
`define CFG_SEL_MSB 5
`define CFG_DAY_EN 6
`define CFG_POST_EN 7
`define CFG_PROVE_EN 8
`define CFG_RESET 9'h001
`define TIME_RESET 8'h14
`define IGNITE_TICKS 8'h14
`define CMD_LOCK_CLR 0

`define MODE_UNSUPPORTED 2'h1
`define SEL_CONTACTS 3'h0
`define SEL_CURRENT_LOCK 3'h4
`define CODE_NONE 8'h00
`define CODE_LOOP_OPEN 8'h16
`define CODE_CURRENT_LOW 8'h3C
`define CODE_BAD_MODE 8'h50

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- load_ctrl_pkg.sv
// Purpose: Types shared by the load controller and its input filter
// Assumes: Constants come from load_ctrl_params.svh
// Notes: Phase codes are one-hot
`include "load_ctrl_params.svh"

package load_ctrl_pkg;

  typedef enum logic [7:0] {
    PH_STANDBY = 8'h01,
    PH_PREPURGE = 8'h02,
    PH_IGNITE = 8'h04,
    PH_OPERATE = 8'h08,
    PH_SHUT_DRIVE = 8'h10,
    PH_POSTPURGE = 8'h20,
    PH_PROVING = 8'h40,
    PH_LOCKOUT = 8'h80
  } phase_e;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [2:0] hist;
    logic lastMaj;
    logic level;
  } vote_s;

  typedef struct packed {
    phase_e phase;
    logic [`TICK_W-1:0] tickCnt;
    logic tick;
    logic [7:0] phaseTmr;
    logic [`RUN_W-1:0] runTicks;
    logic [7:0] lockCode;
    logic loopS1;
    logic loopS2;
    logic lowS1;
    logic lowS2;
    logic curS1;
    logic curS2;
    logic [`CFG_W-1:0] cfg;
    logic [7:0] shutTime;
    logic [7:0] purgeTime;
    logic [7:0] postTime;
    logic [7:0] proveTime;
    logic actLow;
    logic actHigh;
    logic fuel;
    logic fan;
    logic ignite;
    logic loopSupply;
    logic alarm;
    logic operating;
    logic awRdy;
    logic awHeld;
    logic [7:0] awAddr;
    logic wRdy;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } ctrl_s;

endpackage

//--- load_partner.sv
// Purpose: Contact, safety loop and actuator model facing the controller
// Assumes: Actuator moves one step per clock while driven
// Notes: Bench commands set contact levels, held for whole ticks
`timescale 1ns/1ps

module load_partner
#(
  parameter int POS_MAX = 40
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic heatCmd,
  input wire logic closeCmd,
  input wire logic openCmd,
  input wire logic loopCmd,
  input wire logic curLowCmd,
  input wire logic actuatorLowDrive,
  input wire logic actuatorHighDrive,
  output logic heatReqPin,
  output logic loadClosePin,
  output logic loadOpenPin,
  output logic safetyLoopPin,
  output logic lowFireFbPin,
  output logic currentLowPin
);
  int pos_reg;

  assign heatReqPin = heatCmd;
  assign loadClosePin = closeCmd;
  assign loadOpenPin = openCmd;
  assign safetyLoopPin = loopCmd;
  assign currentLowPin = curLowCmd;
  // Feedback only at the end stop, so a short run never reports low-fire
  assign lowFireFbPin = (pos_reg == 0);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pos_reg <= POS_MAX / 2;
    else if (actuatorLowDrive && pos_reg > 0)
      pos_reg <= pos_reg - 1;
    else if (actuatorHighDrive && pos_reg < POS_MAX)
      pos_reg <= pos_reg + 1;
  end
endmodule // load_partner

//--- load_request_safety_loop_ctrl.sv
// Purpose: Heat request, load contacts, shutdown run and safety loop handling
// Assumes: Contacts active high after level shifting, AXI4-Lite register access
// Notes: Safety loop and feedback pins are synchronised but not voted
`timescale 1ns/1ps
`include "load_ctrl_params.svh"

module load_request_safety_loop_ctrl
#(
  parameter int TICK_CYCLES = `SAMPLE_CYCLES,
  parameter int DAY_TICKS = `FORCED_STOP_TICKS
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic heatReqPin,
  input wire logic loadClosePin,
  input wire logic loadOpenPin,
  input wire logic safetyLoopPin,
  input wire logic lowFireFbPin,
  input wire logic currentLowPin,
  output logic actuatorLowDrive,
  output logic actuatorHighDrive,
  output logic fuelValve,
  output logic fanMotor,
  output logic ignition,
  output logic loopSupply,
  output logic alarm,
  output logic operating_phase,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  load_ctrl_pkg::ctrl_s s_reg;
  load_ctrl_pkg::ctrl_s s_next;
  logic [2:0] pins;
  logic [2:0] voted;
  logic heatReq;
  logic loopOpen;
  logic done;
  logic lockTrig;
  logic lockClr;
  logic [7:0] lockCode;
  logic [31:0] merged;
  logic [1:0] mode;
  logic [2:0] sel;

  assign pins = {loadOpenPin, loadClosePin, heatReqPin};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_vote
      vote_filter u_vote
      (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pinIn(pins[gi]),
        .sampleTick(s_reg.tick),
        .level(voted[gi])
      );
    end
  endgenerate

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
    input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] readImage(input load_ctrl_pkg::ctrl_s st, input logic [7:0] addr,
    input logic [2:0] v);
    logic [31:0] img;
    img = 32'h0000_0000;
    case (addr)
      `REG_CONFIG: img[`CFG_W-1:0] = st.cfg;
      `REG_SHUT_TIME: img[7:0] = st.shutTime;
      `REG_PURGE_TIME: img[7:0] = st.purgeTime;
      `REG_POST_TIME: img[7:0] = st.postTime;
      `REG_PROVE_TIME: img[7:0] = st.proveTime;
      `REG_STATUS: img = {9'h000, v, st.loopS2, st.lowS2, st.curS2, st.loopSupply, st.lockCode, st.phase};
      default: img = 32'h0000_0000;
    endcase
    return img;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return (addr == `REG_CONFIG) || (addr == `REG_SHUT_TIME) || (addr == `REG_PURGE_TIME)
      || (addr == `REG_POST_TIME) || (addr == `REG_PROVE_TIME) || (addr == `REG_STATUS)
      || (addr == `REG_COMMAND);
  endfunction

  always_comb
  begin
    s_next = s_reg;
    heatReq = voted[0];
    mode = s_reg.cfg[`CFG_MODE_MSB:`CFG_MODE_LSB];
    sel = s_reg.cfg[`CFG_SEL_MSB:`CFG_SEL_LSB];
    loopOpen = !s_reg.loopS2;
    lockClr = 1'b0;
    merged = 32'h0000_0000;

    // Pin synchronisers
    s_next.loopS1 = safetyLoopPin;
    s_next.loopS2 = s_reg.loopS1;
    s_next.lowS1 = lowFireFbPin;
    s_next.lowS2 = s_reg.lowS1;
    s_next.curS1 = currentLowPin;
    s_next.curS2 = s_reg.curS1;

    // Sampling period generator
    s_next.tick = 1'b0;
    if (s_reg.tickCnt == `TICK_W'(TICK_CYCLES - 1))
    begin
      s_next.tickCnt = '0;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.tickCnt = s_reg.tickCnt + `TICK_W'(1);
    end

    // AXI4-Lite write: address and data in either order
    if (awvalid && s_reg.awRdy)
    begin
      s_next.awRdy = 1'b0;
      s_next.awHeld = 1'b1;
      s_next.awAddr = awaddr;
    end
    if (wvalid && s_reg.wRdy)
    begin
      s_next.wRdy = 1'b0;
      s_next.wHeld = 1'b1;
      s_next.wData = wdata;
      s_next.wStrb = wstrb;
    end
    if (s_reg.awHeld && s_reg.wHeld && !s_reg.bValid)
    begin
      s_next.awHeld = 1'b0;
      s_next.wHeld = 1'b0;
      s_next.bValid = 1'b1;
      s_next.bResp = mapped(s_reg.awAddr) ? `RESP_OKAY : `RESP_SLVERR;
      merged = mergeBytes(readImage(s_reg, s_reg.awAddr, voted), s_reg.wData, s_reg.wStrb);
      case (s_reg.awAddr)
        `REG_CONFIG: s_next.cfg = merged[`CFG_W-1:0];
        `REG_SHUT_TIME: s_next.shutTime = merged[7:0];
        `REG_PURGE_TIME: s_next.purgeTime = merged[7:0];
        `REG_POST_TIME: s_next.postTime = merged[7:0];
        `REG_PROVE_TIME: s_next.proveTime = merged[7:0];
        `REG_COMMAND: lockClr = s_reg.wStrb[0] && s_reg.wData[`CMD_LOCK_CLR];
        default: lockClr = 1'b0;
      endcase
    end
    if (s_reg.bValid && bready)
    begin
      s_next.bValid = 1'b0;
      s_next.awRdy = 1'b1;
      s_next.wRdy = 1'b1;
    end

    // AXI4-Lite read
    if (arvalid && s_reg.arRdy)
    begin
      s_next.arRdy = 1'b0;
      s_next.rValid = 1'b1;
      s_next.rData = readImage(s_reg, araddr, voted);
      s_next.rResp = (mapped(araddr) && araddr != `REG_COMMAND) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_reg.rValid && rready)
    begin
      s_next.rValid = 1'b0;
      s_next.arRdy = 1'b1;
    end

    // Lockout causes, first found wins the code
    lockTrig = 1'b1;
    lockCode = `CODE_NONE;
    if (loopOpen && heatReq)
    begin
      lockCode = `CODE_LOOP_OPEN;
    end
    else if (mode == `MODE_UNSUPPORTED)
    begin
      lockCode = `CODE_BAD_MODE;
    end
    else if (sel == `SEL_CURRENT_LOCK && s_reg.curS2 && s_reg.phase == load_ctrl_pkg::PH_OPERATE)
    begin
      lockCode = `CODE_CURRENT_LOW;
    end
    else
    begin
      lockTrig = 1'b0;
    end

    // Phase timer counts sampling periods
    if (s_reg.tick && s_reg.phaseTmr != 8'hFF)
    begin
      s_next.phaseTmr = s_reg.phaseTmr + 8'h01;
    end
    if (s_reg.tick && s_reg.phase == load_ctrl_pkg::PH_OPERATE && s_reg.runTicks != `RUN_W'(DAY_TICKS))
    begin
      s_next.runTicks = s_reg.runTicks + `RUN_W'(1);
    end

    done = 1'b0;
    if (lockTrig && s_reg.phase != load_ctrl_pkg::PH_LOCKOUT)
    begin
      s_next.phase = load_ctrl_pkg::PH_LOCKOUT;
      s_next.lockCode = lockCode;
    end
    else
    begin
      case (s_reg.phase)
        load_ctrl_pkg::PH_STANDBY:
        begin
          if (heatReq && !loopOpen)
          begin
            s_next.phase = load_ctrl_pkg::PH_PREPURGE;
          end
        end
        load_ctrl_pkg::PH_PREPURGE:
        begin
          if (!heatReq)
          begin
            s_next.phase = load_ctrl_pkg::PH_STANDBY;
          end
          else if (s_reg.phaseTmr >= s_reg.purgeTime)
          begin
            s_next.phase = load_ctrl_pkg::PH_IGNITE;
          end
        end
        load_ctrl_pkg::PH_IGNITE:
        begin
          if (!heatReq)
          begin
            s_next.phase = load_ctrl_pkg::PH_STANDBY;
          end
          else if (s_reg.phaseTmr >= `IGNITE_TICKS)
          begin
            s_next.phase = load_ctrl_pkg::PH_OPERATE;
            s_next.runTicks = '0;
          end
        end
        load_ctrl_pkg::PH_OPERATE:
        begin
          // Forced stop restarts from standby while heat is still requested
          if (!heatReq || (s_reg.cfg[`CFG_DAY_EN] && s_reg.runTicks == `RUN_W'(DAY_TICKS)))
          begin
            if (s_reg.shutTime == 8'h00)
            begin
              done = 1'b1;
            end
            else
            begin
              s_next.phase = load_ctrl_pkg::PH_SHUT_DRIVE;
            end
          end
        end
        load_ctrl_pkg::PH_SHUT_DRIVE:
        begin
          done = (s_reg.phaseTmr >= s_reg.shutTime) || s_reg.lowS2;
        end
        load_ctrl_pkg::PH_POSTPURGE:
        begin
          if (s_reg.phaseTmr >= s_reg.postTime)
          begin
            s_next.phase = s_reg.cfg[`CFG_PROVE_EN] ? load_ctrl_pkg::PH_PROVING : load_ctrl_pkg::PH_STANDBY;
          end
        end
        load_ctrl_pkg::PH_PROVING:
        begin
          if (s_reg.phaseTmr >= s_reg.proveTime)
          begin
            s_next.phase = load_ctrl_pkg::PH_STANDBY;
          end
        end
        load_ctrl_pkg::PH_LOCKOUT:
        begin
          // Only a software clear leaves lockout; heat cycling does not
          if (lockClr && !lockTrig)
          begin
            s_next.phase = load_ctrl_pkg::PH_STANDBY;
            s_next.lockCode = `CODE_NONE;
          end
        end
        default:
        begin
          s_next.phase = load_ctrl_pkg::PH_LOCKOUT;
        end
      endcase
    end
    if (done)
    begin
      if (s_reg.cfg[`CFG_POST_EN])
      begin
        s_next.phase = load_ctrl_pkg::PH_POSTPURGE;
      end
      else
      begin
        s_next.phase = s_reg.cfg[`CFG_PROVE_EN] ? load_ctrl_pkg::PH_PROVING : load_ctrl_pkg::PH_STANDBY;
      end
    end
    if (s_next.phase != s_reg.phase)
    begin
      s_next.phaseTmr = 8'h00;
    end

    // Output drive per phase
    s_next.fan = 1'b0;
    s_next.fuel = 1'b0;
    s_next.ignite = 1'b0;
    s_next.actLow = 1'b0;
    s_next.actHigh = 1'b0;
    case (s_next.phase)
      load_ctrl_pkg::PH_PREPURGE:
      begin
        s_next.fan = 1'b1;
        s_next.actHigh = 1'b1;
      end
      load_ctrl_pkg::PH_IGNITE:
      begin
        s_next.fan = 1'b1;
        s_next.fuel = 1'b1;
        s_next.ignite = 1'b1;
        s_next.actLow = 1'b1;
      end
      load_ctrl_pkg::PH_OPERATE:
      begin
        s_next.fan = 1'b1;
        s_next.fuel = 1'b1;
        // Close wins if both contacts are made, the safer direction
        if (sel == `SEL_CONTACTS)
        begin
          s_next.actLow = voted[1];
          s_next.actHigh = voted[2] && !voted[1];
        end
      end
      load_ctrl_pkg::PH_SHUT_DRIVE:
      begin
        s_next.fan = 1'b1;
        s_next.fuel = 1'b1;
        s_next.actLow = 1'b1;
      end
      load_ctrl_pkg::PH_POSTPURGE:
      begin
        s_next.fan = 1'b1;
      end
      default:
      begin
        s_next.fan = 1'b0;
      end
    endcase
    if (!s_reg.cfg[`CFG_ACT_ON])
    begin
      s_next.actLow = 1'b0;
      s_next.actHigh = 1'b0;
    end
    if (loopOpen)
    begin
      s_next.fan = 1'b0;
      s_next.fuel = 1'b0;
      s_next.ignite = 1'b0;
    end
    s_next.loopSupply = heatReq && s_next.phase != load_ctrl_pkg::PH_LOCKOUT;
    s_next.alarm = s_next.phase == load_ctrl_pkg::PH_LOCKOUT;
    s_next.operating = s_next.phase == load_ctrl_pkg::PH_OPERATE;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
      s_reg.phase <= load_ctrl_pkg::PH_STANDBY;
      s_reg.cfg <= `CFG_RESET;
      s_reg.shutTime <= `TIME_RESET;
      s_reg.purgeTime <= `TIME_RESET;
      s_reg.postTime <= `TIME_RESET;
      s_reg.proveTime <= `TIME_RESET;
      s_reg.awRdy <= 1'b1;
      s_reg.wRdy <= 1'b1;
      s_reg.arRdy <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign actuatorLowDrive = s_reg.actLow;
  assign actuatorHighDrive = s_reg.actHigh;
  assign fuelValve = s_reg.fuel;
  assign fanMotor = s_reg.fan;
  assign ignition = s_reg.ignite;
  assign loopSupply = s_reg.loopSupply;
  assign alarm = s_reg.alarm;
  assign operating_phase = s_reg.operating;
  assign awready = s_reg.awRdy;
  assign wready = s_reg.wRdy;
  assign bvalid = s_reg.bValid;
  assign bresp = s_reg.bResp;
  assign arready = s_reg.arRdy;
  assign rvalid = s_reg.rValid;
  assign rdata = s_reg.rData;
  assign rresp = s_reg.rResp;

endmodule // load_request_safety_loop_ctrl

//--- load_request_safety_loop_ctrl_tb.sv
// Purpose: Self-checking bench for the load request and safety loop controller
// Assumes: Tick shortened to 4 cycles, day count to 50 ticks
// Notes: Contacts come from the partner model, registers over AXI4-Lite
`timescale 1ns/1ps
`include "load_ctrl_params.svh"

module load_request_safety_loop_ctrl_tb;
  localparam int TICK = 4;
  localparam int FAN = 0, LOWD = 1, HIGHD = 2, OPER = 3, ALRM = 4;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic heatCmd = 1'h0, closeCmd = 1'h0, openCmd = 1'h0, loopCmd = 1'h1, curLowCmd = 1'h0;
  logic heatReqPin, loadClosePin, loadOpenPin, safetyLoopPin, lowFireFbPin, currentLowPin;
  logic actuatorLowDrive, actuatorHighDrive, fuelValve, fanMotor, ignition, loopSupply, alarm, operating_phase;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  int n_mismatch = 0, num_checks = 0;

  always #10 clk_sys = ~clk_sys;

  load_partner partner (.clk_sys(clk_sys), .rst_n(rst_n), .heatCmd(heatCmd), .closeCmd(closeCmd),
    .openCmd(openCmd), .loopCmd(loopCmd), .curLowCmd(curLowCmd), .actuatorLowDrive(actuatorLowDrive),
    .actuatorHighDrive(actuatorHighDrive), .heatReqPin(heatReqPin), .loadClosePin(loadClosePin),
    .loadOpenPin(loadOpenPin), .safetyLoopPin(safetyLoopPin), .lowFireFbPin(lowFireFbPin),
    .currentLowPin(currentLowPin));

  load_request_safety_loop_ctrl #(.TICK_CYCLES(TICK), .DAY_TICKS(50)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .heatReqPin(heatReqPin), .loadClosePin(loadClosePin), .loadOpenPin(loadOpenPin),
    .safetyLoopPin(safetyLoopPin), .lowFireFbPin(lowFireFbPin), .currentLowPin(currentLowPin),
    .actuatorLowDrive(actuatorLowDrive), .actuatorHighDrive(actuatorHighDrive), .fuelValve(fuelValve),
    .fanMotor(fanMotor), .ignition(ignition), .loopSupply(loopSupply), .alarm(alarm),
    .operating_phase(operating_phase), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic results();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bound(input int k, input int lim);
    if (k >= lim)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, k, lim);
      results();
    end
  endtask

  function automatic logic outSel(input int i);
    case (i)
      FAN: return fanMotor;
      LOWD: return actuatorLowDrive;
      HIGHD: return actuatorHighDrive;
      OPER: return operating_phase;
      default: return alarm;
    endcase
  endfunction

  task automatic waitSig(input int i, input logic v, input int lim);
    int k;
    for (k = 0; k < lim; k++)
    begin
      @(posedge clk_sys);
      if (outSel(i) === v)
        break;
    end
    bound(k, lim);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_sys);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
      if (bvalid)
        break;
    end
    r = bresp;
    bready <= 1'h0;
    bound(k, 20);
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_sys);
      if (arready)
        arvalid <= 1'h0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    bound(k, 20);
  endtask

  task automatic runUp();
    heatCmd <= 1'h1;
    waitSig(OPER, 1'h1, 400);
  endtask

  task automatic t_regs();
    rd(`REG_CONFIG);
    chk(d, 32'h0000_0001);
    wr(`REG_PURGE_TIME, 32'h0000_0003);
    wr(`REG_SHUT_TIME, 32'h0000_00FF);
    chk(32'(r), 32'(`RESP_OKAY));
    rd(`REG_SHUT_TIME);
    chk(d, 32'h0000_00FF);
    rd(8'h1C);
    chk(32'(r), 32'(`RESP_SLVERR));
  endtask

  task automatic t_idle();
    closeCmd <= 1'h1;
    heatCmd <= 1'h1;
    repeat (TICK) @(posedge clk_sys);
    heatCmd <= 1'h0;
    repeat (10 * TICK) @(posedge clk_sys);
    chk(32'(fanMotor), 32'h0000_0000);
    chk(32'(actuatorLowDrive), 32'h0000_0000);
    rd(`REG_STATUS);
    chk(32'(d[22:20]), 32'h0000_0002);
    closeCmd <= 1'h0;
  endtask

  task automatic t_start();
    heatCmd <= 1'h1;
    waitSig(FAN, 1'h1, 100);
    chk(32'(actuatorHighDrive), 32'h0000_0001);
    waitSig(OPER, 1'h1, 400);
    chk(32'(fuelValve), 32'h0000_0001);
  endtask

  task automatic t_load();
    openCmd <= 1'h1;
    repeat (TICK) @(posedge clk_sys);
    openCmd <= 1'h0;
    repeat (10 * TICK) @(posedge clk_sys);
    chk(32'(actuatorHighDrive), 32'h0000_0000);
    openCmd <= 1'h1;
    closeCmd <= 1'h1;
    waitSig(LOWD, 1'h1, 60);
    chk(32'(actuatorHighDrive), 32'h0000_0000);
    closeCmd <= 1'h0;
    waitSig(HIGHD, 1'h1, 60);
    openCmd <= 1'h0;
    waitSig(HIGHD, 1'h0, 60);
    chk(32'(actuatorLowDrive), 32'h0000_0000);
  endtask

  task automatic t_shut();
    heatCmd <= 1'h0;
    waitSig(LOWD, 1'h1, 100);
    chk(32'(operating_phase), 32'h0000_0000);
    waitSig(LOWD, 1'h0, 120);
    repeat (4) @(posedge clk_sys);
    rd(`REG_STATUS);
    chk(32'(d[7:0]), 32'h0000_0001);
    chk(32'(fanMotor), 32'h0000_0000);
  endtask

  task automatic t_post();
    int seen;
    wr(`REG_CONFIG, 32'h0000_0181);
    wr(`REG_SHUT_TIME, 32'h0000_0000);
    wr(`REG_POST_TIME, 32'h0000_0003);
    runUp();
    heatCmd <= 1'h0;
    waitSig(OPER, 1'h0, 100);
    repeat (8)
    begin
      @(posedge clk_sys);
      seen = seen | actuatorLowDrive;
    end
    chk(32'(seen), 32'h0000_0000);
    chk(32'({fanMotor, fuelValve}), 32'h0000_0002);
    waitSig(FAN, 1'h0, 100);
    rd(`REG_STATUS);
    chk(32'(d[7:0]), 32'h0000_0040);
  endtask

  task automatic t_day();
    wr(`REG_CONFIG, 32'h0000_0041);
    runUp();
    waitSig(OPER, 1'h0, 300);
    waitSig(OPER, 1'h1, 400);
    heatCmd <= 1'h0;
    waitSig(FAN, 1'h0, 200);
  endtask

  task automatic t_loop();
    wr(`REG_CONFIG, 32'h0000_0001);
    runUp();
    chk(32'(loopSupply), 32'h0000_0001);
    loopCmd <= 1'h0;
    repeat (6) @(posedge clk_sys);
    chk(32'(fuelValve | fanMotor | ignition), 32'h0000_0000);
    waitSig(ALRM, 1'h1, 20);
    rd(`REG_STATUS);
    chk(32'(d[15:8]), 32'(`CODE_LOOP_OPEN));
    chk(32'(loopSupply), 32'h0000_0000);
    heatCmd <= 1'h0;
    loopCmd <= 1'h1;
    repeat (20) @(posedge clk_sys);
    wr(`REG_COMMAND, 32'h0000_0001);
    waitSig(ALRM, 1'h0, 20);
  endtask

  task automatic t_mode();
    wr(`REG_CONFIG, 32'h0000_0003);
    waitSig(ALRM, 1'h1, 20);
    rd(`REG_STATUS);
    chk(32'(d[15:8]), 32'(`CODE_BAD_MODE));
    wr(`REG_CONFIG, 32'h0000_0001);
    wr(`REG_COMMAND, 32'h0000_0001);
    waitSig(ALRM, 1'h0, 20);
  endtask

  task automatic t_cur();
    wr(`REG_CONFIG, 32'h0000_0021);
    curLowCmd <= 1'h1;
    heatCmd <= 1'h1;
    waitSig(ALRM, 1'h1, 400);
    rd(`REG_STATUS);
    chk(32'(d[15:8]), 32'(`CODE_CURRENT_LOW));
  endtask

  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_regs();
    t_idle();
    t_start();
    t_load();
    t_shut();
    t_post();
    t_day();
    t_loop();
    t_mode();
    t_cur();
    results();
  end
endmodule // load_request_safety_loop_ctrl_tb

//--- vote_filter.sv
// Purpose: Contact input filter with 2-out-of-3 vote per sample
// Assumes: sampleTick is a one-cycle pulse once per sampling period
// Notes: Level changes only after the same vote in two successive samples
`timescale 1ns/1ps
`include "load_ctrl_params.svh"

module vote_filter
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pinIn,
  input wire logic sampleTick,
  output logic level
);

  load_ctrl_pkg::vote_s state_reg;
  load_ctrl_pkg::vote_s state_next;
  logic maj;

  always_comb
  begin
    state_next = state_reg;
    state_next.sync1 = pinIn;
    state_next.sync2 = state_reg.sync1;
    maj = 1'b0;
    if (sampleTick)
    begin
      state_next.hist = {state_reg.hist[1:0], state_reg.sync2};
      // Majority of the three newest samples
      maj = (state_next.hist[0] & state_next.hist[1]) | (state_next.hist[1] & state_next.hist[2])
        | (state_next.hist[0] & state_next.hist[2]);
      if (maj == state_reg.lastMaj)
      begin
        state_next.level = maj;
      end
      state_next.lastMaj = maj;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.level;

endmodule // vote_filter
